/* bench/pcs_host_model.sv */
// host bridge model issuing configuration cycles
module pcs_host_model
  import pcs_pkg::*;
(
  // clock
  input wire logic clk,
  // configuration access
  output pcs_pkg::pcs_cfg_req_t cfgReq,
  input wire pcs_pkg::pcs_cfg_rsp_t cfgRsp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfgReq = '0;
  end
  // idle fields are inverted so a stale request never looks valid
  task automatic access(input logic wr, input logic [7:0] a,
      input logic [3:0] be, input logic [31:0] wd,
      output logic ack, output logic [31:0] rd);
    @(negedge clk);
    cfgReq <= '{1'b1, wr, a, be, wd};
    @(negedge clk);
    cfgReq <= '{1'b0, ~wr, ~a, ~be, ~wd};
    ack = cfgRsp.ack;
    rd = cfgRsp.rdata;
  endtask : access
endmodule : pcs_host_model

/* bench/tb.sv */
// self-checking bench for the command and status bank
module tb import pcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  pcs_cfg_req_t cfgReq;
  pcs_cfg_rsp_t cfgRsp;
  pcs_evt_t evt;
  logic masterReq, memHit, ioHit, busReq, memSelect, ioSelect;
  logic masterEnable, memSpaceEnable, ioSpaceEnable;
  logic [15:0] expSts;
  logic [2:0] expCmd;
  logic [7:0] ua;
  logic [2:0] k;
  int fails = 0;
  int testsRun = 0;
  int cycles = 0;
  // event words: parity, sys, mabort, special, trcv, tsent, master_parity_error
  logic [6:0] evTab [7] = '{7'h18, 7'h10, 7'h40, 7'h20, 7'h04, 7'h02,
      7'h01};
  logic [15:0] stTab [7] = '{16'h0000, 16'h2000, 16'h8000, 16'h4000,
      16'h1000, 16'h0800, 16'h0100};

  pcs_regs u_pcs_regs (.clk(clk), .reset_n(reset_n), .cfgReq(cfgReq),
    .cfgRsp(cfgRsp), .evt(evt), .masterReq(masterReq), .busReq(busReq),
    .memHit(memHit), .ioHit(ioHit), .memSelect(memSelect),
    .ioSelect(ioSelect), .masterEnable(masterEnable),
    .memSpaceEnable(memSpaceEnable), .ioSpaceEnable(ioSpaceEnable));
  pcs_host_model u_pcs_host_model (.clk(clk), .cfgReq(cfgReq),
    .cfgRsp(cfgRsp));

  always #10 clk = ~clk;
  // a hang is cut short well past the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] expWord();
    return {expSts, 13'h0, expCmd};
  endfunction : expWord

  task automatic check(input logic [31:0] g, input logic [31:0] e,
      input string what);
    testsRun++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask : check

  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [3:0] be, input logic [31:0] wd, input logic [31:0] e);
    logic ack;
    logic [31:0] rd;
    u_pcs_host_model.access(wr, a, be, wd, ack, rd);
    check({31'h0, ack}, 32'h1, "ack");
    check(rd, wr ? 32'h0 : e, "read data");
  endtask : xfer

  task automatic gate_round();
    logic [2:0] h;
    h = 3'($urandom);
    @(negedge clk);
    masterReq = h[2];
    memHit = h[1];
    ioHit = h[0];
    @(negedge clk);
    check({29'h0, busReq, memSelect, ioSelect},
        {29'h0, h & expCmd}, "gated outputs");
    check({29'h0, masterEnable,
        memSpaceEnable, ioSpaceEnable}, {29'h0, expCmd}, "enables");
  endtask : gate_round

  task automatic report_and_stop();
    $display("tests_run %0d fails %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    evt = '0;
    masterReq = 1'b0;
    memHit = 1'b0;
    ioHit = 1'b0;
    void'($urandom(32'h1C15));
    // medium select timing plus capability bit
    expSts = 16'h0210;
    expCmd = 3'h0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) gate_round();
    xfer(1'b0, CFG_CMD_OFS, 4'hF, $urandom, expWord());
    // status lanes and lanes without the command byte must not stick
    xfer(1'b1, CFG_STS_OFS, 4'hC, 32'hFFFFFFFF, 32'h0);
    xfer(1'b1, CFG_CMD_OFS, 4'hE, 32'hFFFFFFFF, 32'h0);
    xfer(1'b0, CFG_CMD_OFS, 4'hF, $urandom, expWord());
    k = 3'($urandom);
    for (int i = 0; i < 8; i++) begin
      expCmd = 3'(i) ^ k;
      xfer(1'b1, CFG_CMD_OFS, 4'($urandom) | 4'h1,
          ($urandom & 32'hFFFFFFF8) | 32'(expCmd), 32'h0);
      xfer(1'b0, CFG_CMD_OFS, 4'hF, $urandom, expWord());
      repeat (4) gate_round();
    end
    repeat (6) begin
      ua = {6'($urandom), 2'h0};
      if (ua[7:2] == 6'h01) begin
        ua = 8'h00;
      end
      xfer(1'b1, ua, 4'hF, $urandom, 32'h0);
      xfer(1'b0, ua, 4'hF, $urandom, 32'h0);
    end
    xfer(1'b0, CFG_CMD_OFS, 4'hF, $urandom, expWord());
    for (int i = 0; i < 7; i++) begin
      @(negedge clk);
      evt = evTab[i];
      @(negedge clk);
      evt = '0;
      expSts = expSts | stTab[i];
      xfer(1'b0, CFG_CMD_OFS, 4'hF, $urandom, expWord());
    end
    xfer(1'b1, CFG_CMD_OFS, 4'hC, 32'h0, 32'h0);
    xfer(1'b0, CFG_CMD_OFS, 4'hF, $urandom, expWord());
    // second reset in mid-run clears enables and flags
    @(negedge clk);
    reset_n = 1'b0;
    @(negedge clk);
    check({29'h0, masterEnable,
        memSpaceEnable, ioSpaceEnable}, 32'h0, "enables in reset");
    check({29'h0, busReq, memSelect, ioSelect},
        32'h0, "claims in reset");
    reset_n = 1'b1;
    expSts = 16'h0210;
    expCmd = 3'h0;
    xfer(1'b0, CFG_CMD_OFS, 4'hF, $urandom, expWord());
    repeat (3) gate_round();
    report_and_stop();
  end
endmodule : tb

/* logic/pcs_pkg.sv */
// constants, carriers and the plain-words rule summary for the cmd/status bank
// Operation
// - master_enable clear: no initiator transactions; resets 0
// - master_enable set: may arbitrate, run master cycles
// - memory_space_enable gates memory responses; resets 0
// - io_space_enable gates I/O responses; resets 0
// - 16-bit status at 06h, write-proof
// - status fields placed at documented bit positions
// - status resets: select_timing 01, capability bit 1
// - select_timing 00 fast, 01 medium, 10 slow
// - parity error always sets parity_error_detected
// - master abort received (not on a special cycle) or target abort received sets flags
package pcs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_CMD_OFS = 8'h04;
  localparam logic [7:0] CFG_STS_OFS = 8'h06;
  localparam logic [31:0] CFG_UNMAPPED_DATA = 32'h00000000;

  // command bit positions
  localparam int CMD_IO_BIT = 0;
  localparam int CMD_MEM_BIT = 1;
  localparam int CMD_MASTER_BIT = 2;
  localparam int CMD_WIDTH = 3;
  localparam logic [2:0] CMD_RESET = 3'h0;

  // status bit positions
  localparam int STS_PARITY_DET = 15;
  localparam int STS_SYS_ERR = 14;
  localparam int STS_MABORT_RCV = 13;
  localparam int STS_TABORT_RCV = 12;
  localparam int STS_TABORT_SIG = 11;
  localparam int STS_SEL_HI = 10;
  localparam int STS_SEL_LO = 9;
  localparam int STS_MDATA_PAR = 8;
  localparam int STS_B2B_CAP = 7;
  localparam int STS_FAST_CLK = 5;
  localparam int STS_CAP_LIST = 4;
  localparam logic [15:0] STS_RESET = 16'h0210;

  // select_timing encodings
  localparam logic [1:0] SEL_FAST = 2'h0;
  localparam logic [1:0] SEL_MEDIUM = 2'h1;
  localparam logic [1:0] SEL_SLOW = 2'h2;

  // sticky flag indices
  localparam int FLG_MDATA_PAR = 0;
  localparam int FLG_TABORT_SIG = 1;
  localparam int FLG_TABORT_RCV = 2;
  localparam int FLG_MABORT_RCV = 3;
  localparam int FLG_SYS_ERR = 4;
  localparam int FLG_PARITY_DET = 5;
  localparam int FLG_NUM = 6;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] byteEn;
    logic [31:0] wdata;
  } pcs_cfg_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } pcs_cfg_rsp_t;

  typedef struct packed {
    logic parityErr;
    logic sysErr;
    logic masterAbort;
    logic specialCycle;
    logic targetAbortRcvd;
    logic targetAbortSent;
    logic masterDataParity;
  } pcs_evt_t;

endpackage : pcs_pkg

/* logic/pcs_regs.sv */
// command enable bits and status register behind configuration cycles
module pcs_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // configuration access
  input wire pcs_pkg::pcs_cfg_req_t cfgReq,
  output pcs_pkg::pcs_cfg_rsp_t cfgRsp,
  // bus events from the interface core
  input wire pcs_pkg::pcs_evt_t evt,
  // master request path
  input wire logic masterReq,
  output logic busReq,
  // target decode path
  input wire logic memHit,
  input wire logic ioHit,
  output logic memSelect,
  output logic ioSelect,
  // enables for the rest of the controller
  output logic masterEnable,
  output logic memSpaceEnable,
  output logic ioSpaceEnable
);
  import pcs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [CMD_WIDTH-1:0] cmd_q;
  logic [CMD_WIDTH-1:0] cmd_d;
  pcs_cfg_rsp_t rsp_q;
  pcs_cfg_rsp_t rsp_d;
  logic busReq_q;
  logic busReq_d;
  logic memSel_q;
  logic memSel_d;
  logic ioSel_q;
  logic ioSel_d;
  logic [FLG_NUM-1:0] flagSet;
  logic [FLG_NUM-1:0] flags;
  logic [15:0] statusVal;
  logic cmdHit;

  // ----------------------------------------------------------------
  // sticky status flags
  // ----------------------------------------------------------------
  always_comb begin
    flagSet = '0;
    flagSet[FLG_PARITY_DET] = evt.parityErr;
    flagSet[FLG_SYS_ERR] = evt.sysErr;
    flagSet[FLG_MABORT_RCV] = evt.masterAbort && !evt.specialCycle;
    flagSet[FLG_TABORT_RCV] = evt.targetAbortRcvd;
    flagSet[FLG_TABORT_SIG] = evt.targetAbortSent;
    flagSet[FLG_MDATA_PAR] = evt.masterDataParity;
  end

  pcs_sticky #(
    .W(FLG_NUM)
  ) u_flags (
    .clk(clk),
    .reset_n(reset_n),
    .set(flagSet),
    .flags(flags)
  );

  // ----------------------------------------------------------------
  // status image
  // ----------------------------------------------------------------
  // field placement
  always_comb begin
    statusVal = STS_RESET;
    statusVal[STS_PARITY_DET] = flags[FLG_PARITY_DET];
    statusVal[STS_SYS_ERR] = flags[FLG_SYS_ERR];
    statusVal[STS_MABORT_RCV] = flags[FLG_MABORT_RCV];
    statusVal[STS_TABORT_RCV] = flags[FLG_TABORT_RCV];
    statusVal[STS_TABORT_SIG] = flags[FLG_TABORT_SIG];
    statusVal[STS_MDATA_PAR] = flags[FLG_MDATA_PAR];
    statusVal[STS_SEL_HI:STS_SEL_LO] = SEL_MEDIUM;
    statusVal[STS_B2B_CAP] = 1'b0;
    statusVal[STS_FAST_CLK] = 1'b0;
    statusVal[STS_CAP_LIST] = 1'b1;
  end

  // ----------------------------------------------------------------
  // configuration access
  // ----------------------------------------------------------------
  // command and status share one dword; status is the upper half
  assign cmdHit = (cfgReq.addr[7:2] == CFG_CMD_OFS[7:2]);

  always_comb begin
    cmd_d = cmd_q;
    rsp_d.ack = cfgReq.valid;
    rsp_d.rdata = CFG_UNMAPPED_DATA;
    if (cfgReq.valid && cfgReq.write && cmdHit && cfgReq.byteEn[0]) begin
      cmd_d = cfgReq.wdata[CMD_WIDTH-1:0];
    end
    if (cfgReq.valid && !cfgReq.write && cmdHit) begin
      rsp_d.rdata = {statusVal, 13'h0000, cmd_q};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_q <= CMD_RESET;
      rsp_q <= '0;
    end else begin
      cmd_q <= cmd_d;
      rsp_q <= rsp_d;
    end
  end

  // ----------------------------------------------------------------
  // enables applied to the bus
  // ----------------------------------------------------------------
  always_comb begin
    busReq_d = masterReq && cmd_q[CMD_MASTER_BIT];
    memSel_d = memHit && cmd_q[CMD_MEM_BIT];
    ioSel_d = ioHit && cmd_q[CMD_IO_BIT];
  end

  // claim outputs trail the hit by one clock, i.e. medium timing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busReq_q <= 1'b0;
      memSel_q <= 1'b0;
      ioSel_q <= 1'b0;
    end else begin
      busReq_q <= busReq_d;
      memSel_q <= memSel_d;
      ioSel_q <= ioSel_d;
    end
  end

  assign cfgRsp = rsp_q;
  assign busReq = busReq_q;
  assign memSelect = memSel_q;
  assign ioSelect = ioSel_q;
  assign masterEnable = cmd_q[CMD_MASTER_BIT];
  assign memSpaceEnable = cmd_q[CMD_MEM_BIT];
  assign ioSpaceEnable = cmd_q[CMD_IO_BIT];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic readCmd;
  assign readCmd = cfgReq.valid && !cfgReq.write && cmdHit;

  property p_no_master;
    !cmd_q[CMD_MASTER_BIT] |=> !busReq_q;
  endproperty
  a_no_master: assert property (p_no_master)
    else $error("bus request while master disabled");

  property p_master_ok;
    masterReq && cmd_q[CMD_MASTER_BIT] |=> busReq_q;
  endproperty
  a_master_ok: assert property (p_master_ok)
    else $error("enabled master request not forwarded");

  property p_mem_gate;
    memHit |=> (memSel_q == $past(cmd_q[CMD_MEM_BIT]));
  endproperty
  a_mem_gate: assert property (p_mem_gate)
    else $error("memory claim disagrees with enable");

  property p_io_gate;
    ioHit |=> (ioSel_q == $past(cmd_q[CMD_IO_BIT]));
  endproperty
  a_io_gate: assert property (p_io_gate)
    else $error("io claim disagrees with enable");

  property p_status_hold;
    cfgReq.valid && cfgReq.write && cmdHit |=> (($past(flags) & ~flags) == '0);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("status bit cleared by a write");

  property p_status_image;
    readCmd |=> rsp_q.ack && (rsp_q.rdata[31:16] & 16'h06BF) == 16'h0210;
  endproperty
  a_status_image: assert property (p_status_image)
    else $error("status constant fields wrong");

  property p_status_flags;
    readCmd |=> rsp_q.rdata[31:27] == $past({flags[5:1]});
  endproperty
  a_status_flags: assert property (p_status_flags)
    else $error("status flag placement wrong");

  property p_sel_timing;
    readCmd |=> rsp_q.rdata[26:25] != 2'h3;
  endproperty
  a_sel_timing: assert property (p_sel_timing)
    else $error("reserved select timing read");

  property p_parity;
    evt.parityErr |=> flags[FLG_PARITY_DET];
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity flag not set");

  property p_abort;
    evt.masterAbort && !evt.specialCycle |=> flags[FLG_MABORT_RCV];
  endproperty
  a_abort: assert property (p_abort)
    else $error("master abort flag not set");

  property p_tabort;
    evt.targetAbortRcvd |=> flags[FLG_TABORT_RCV];
  endproperty
  a_tabort: assert property (p_tabort)
    else $error("target abort flag not set");

  // each claim is held against its own space enable, not either one
  property p_no_claim;
    memSel_q || ioSel_q |-> (!memSel_q || $past(cmd_q[CMD_MEM_BIT]))
        && (!ioSel_q || $past(cmd_q[CMD_IO_BIT]));
  endproperty
  a_no_claim: assert property (p_no_claim)
    else $error("claim with spaces disabled");

  c_enable_write: cover property (cfgReq.valid && cfgReq.write && cmdHit);
  c_bus_req: cover property (busReq_q);
  c_mem_claim: cover property (memSel_q);
  c_abort_seen: cover property (flags[FLG_MABORT_RCV]);

endmodule : pcs_regs

/* logic/pcs_sticky.sv */
// bank of sticky event flags, set by hardware, cleared only by reset
module pcs_sticky #(
  parameter int W = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // events
  input wire logic [W-1:0] set,
  // flags
  output logic [W-1:0] flags
);

  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  // no write path clears these, so an event can never be lost
  always_comb begin
    flags_d = flags_q | set;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule : pcs_sticky
